/* logic/prog_fir_pkg.sv */
// Purpose: constants shared by the programmable fir stage and its testbench
// Assumes: one clock domain, byte-wide register port
// Notes: offsets are byte addresses of the register port

package prog_fir_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] TRANSFER_ADDR = 16'h000F;
  localparam logic [15:0] GAIN_ADDR = 16'h0DF9;
  localparam logic [15:0] FIRST_BANK_BASE = 16'h0E00;
  localparam logic [15:0] SECOND_BANK_BASE = 16'h0F00;
  localparam int TRANSFER_BIT = 0;
  localparam int COEF_DEPTH = 128;
  localparam int COEF_IDX_W = 7;
  localparam int COEF_W = 8;
  localparam int COEF_FRAC = 7;

  // ****************************************
  // gain register fields
  // ****************************************
  localparam int SECOND_GAIN_LSB = 4;
  localparam int FIRST_GAIN_LSB = 0;
  localparam int GAIN_FIELD_W = 3;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [7:0] COEF_RESET = 8'h00;
  localparam logic [2:0] GAIN_LOSS_12 = 3'h6;
  localparam logic [2:0] GAIN_LOSS_6 = 3'h7;
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  localparam logic [2:0] GAIN_PLUS_6 = 3'h1;
  localparam logic [2:0] GAIN_PLUS_12 = 3'h2;

  // ****************************************
  // filter modes
  // ****************************************
  localparam logic [2:0] MODE_BYPASS = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
  localparam logic [2:0] MODE_JOINED = 3'h2;
  localparam logic [2:0] MODE_CASCADE = 3'h4;
  localparam logic [2:0] MODE_COMPLEX = 3'h5;

  // ****************************************
  // datapath defaults
  // ****************************************
  localparam int SAMPLE_W_DEF = 16;
  localparam int TAPS_DEF = 8;
  localparam int FIFO_DEPTH_DEF = 8;

endpackage : prog_fir_pkg

/* logic/sample_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: read data comes straight from the storage flops

`timescale 1ns/10ps

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic full, empty, push, pop;

  assign full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty = (wptr_reg == rptr_reg);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_reg[rptr_reg[AW-1:0]];
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;

  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (push) begin
      mem_next[wptr_reg[AW-1:0]] = in_data_in;
      wptr_next = wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = rptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mem_reg <= '{default: '0};
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end

endmodule : sample_fifo

/* logic/prog_fir_stage.sv */
// Purpose: programmable two-bank fir stage on an i/q sample stream
// Assumes: samples and register port share clk_sys_in; mode comes from the control block
// Notes: coefficient writes land in a shadow copy; the transfer strobe copies them live

`timescale 1ns/10ps

module prog_fir_stage import prog_fir_pkg::*; #(
  parameter int SW = SAMPLE_W_DEF,
  parameter int TAPS = TAPS_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // register port
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // mode select from the control block
  input wire logic [2:0] filter_mode_in,
  // upstream samples
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic signed [SW-1:0] sample_i_in,
  input wire logic signed [SW-1:0] sample_q_in,
  // downstream samples
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic signed [SW-1:0] out_i_out,
  output logic signed [SW-1:0] out_q_out
);

  localparam int WIN = 2 * TAPS;
  localparam int ACC = SW + COEF_W + $clog2(WIN) + 3;
  localparam logic signed [ACC-1:0] SMAX = ACC'((64'sd1 <<< (SW - 1)) - 64'sd1);
  localparam logic signed [ACC-1:0] SMIN = -SMAX - ACC'(1);

  if (TAPS < 1 || WIN > COEF_DEPTH || SW < 2) begin : g_bad_params
    $error("prog_fir_stage needs 1..64 taps and a sample width of at least 2");
  end

  // ****************************************
  // arithmetic helpers
  // ****************************************
  function automatic logic signed [ACC-1:0] fir(input logic signed [SW-1:0] w [WIN],
                                                input logic [COEF_W-1:0] c [COEF_DEPTH],
                                                input int woff, input int coff);
    logic signed [ACC-1:0] acc;
    acc = '0;
    for (int k = 0; k < TAPS; k++) begin
      acc = acc + ACC'(w[woff+k] * $signed(c[coff+k]));
    end
    return acc >>> COEF_FRAC;
  endfunction : fir

  function automatic logic signed [ACC-1:0] gain(input logic [2:0] code, input logic signed [ACC-1:0] v);
    logic signed [ACC-1:0] r;
    r = v;
    unique case (code)
      GAIN_LOSS_12: r = v >>> 2;
      GAIN_LOSS_6: r = v >>> 1;
      GAIN_PLUS_6: r = v <<< 1;
      GAIN_PLUS_12: r = v <<< 2;
      default: r = v;
    endcase
    return r;
  endfunction : gain

  function automatic logic signed [SW-1:0] sat(input logic signed [ACC-1:0] v);
    logic signed [SW-1:0] r;
    r = v[SW-1:0];
    if (v > SMAX) begin
      r = SMAX[SW-1:0];
    end else if (v < SMIN) begin
      r = SMIN[SW-1:0];
    end
    return r;
  endfunction : sat

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] gain_reg, gain_next;
  logic [COEF_W-1:0] first_shadow_reg [COEF_DEPTH];
  logic [COEF_W-1:0] first_shadow_next [COEF_DEPTH];
  logic [COEF_W-1:0] second_shadow_reg [COEF_DEPTH];
  logic [COEF_W-1:0] second_shadow_next [COEF_DEPTH];
  logic [COEF_W-1:0] first_live_reg [COEF_DEPTH];
  logic [COEF_W-1:0] first_live_next [COEF_DEPTH];
  logic [COEF_W-1:0] second_live_reg [COEF_DEPTH];
  logic [COEF_W-1:0] second_live_next [COEF_DEPTH];
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic hit_first, hit_second, transfer;
  logic [COEF_IDX_W-1:0] idx;

  assign idx = reg_addr_in[COEF_IDX_W-1:0];
  assign hit_first = (reg_addr_in[15:COEF_IDX_W] == FIRST_BANK_BASE[15:COEF_IDX_W]);
  assign hit_second = (reg_addr_in[15:COEF_IDX_W] == SECOND_BANK_BASE[15:COEF_IDX_W]);
  assign transfer = reg_wr_in && (reg_addr_in == TRANSFER_ADDR) && reg_wdata_in[TRANSFER_BIT];

  always_comb begin
    gain_next = gain_reg;
    first_shadow_next = first_shadow_reg;
    second_shadow_next = second_shadow_reg;
    first_live_next = first_live_reg;
    second_live_next = second_live_reg;
    rdata_next = rdata_reg;
    rvalid_next = reg_rd_in;
    if (reg_wr_in && reg_addr_in == GAIN_ADDR) begin
      // reserved bits 7 and 3 are never stored
      gain_next = {1'b0, reg_wdata_in[SECOND_GAIN_LSB+:GAIN_FIELD_W], 1'b0,
                   reg_wdata_in[FIRST_GAIN_LSB+:GAIN_FIELD_W]};
    end
    if (reg_wr_in && hit_first) begin
      first_shadow_next[idx] = reg_wdata_in;
    end
    if (reg_wr_in && hit_second) begin
      second_shadow_next[idx] = reg_wdata_in;
    end
    if (transfer) begin
      // a write in the same cycle as the transfer is carried along with it
      first_live_next = first_shadow_next;
      second_live_next = second_shadow_next;
    end
    if (reg_rd_in) begin
      // the transfer bit self-clears, so it always reads back zero
      if (reg_addr_in == GAIN_ADDR) begin
        rdata_next = gain_reg;
      end else if (hit_first) begin
        rdata_next = first_shadow_reg[idx];
      end else if (hit_second) begin
        rdata_next = second_shadow_reg[idx];
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      gain_reg <= GAIN_RESET;
      first_shadow_reg <= '{default: COEF_RESET};
      second_shadow_reg <= '{default: COEF_RESET};
      first_live_reg <= '{default: COEF_RESET};
      second_live_reg <= '{default: COEF_RESET};
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      gain_reg <= gain_next;
      first_shadow_reg <= first_shadow_next;
      second_shadow_reg <= second_shadow_next;
      first_live_reg <= first_live_next;
      second_live_reg <= second_live_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

  // ****************************************
  // input buffer
  // ****************************************
  logic fifo_valid, drain_ready, pop;
  logic out_valid_reg, out_valid_next;
  logic [2*SW-1:0] fifo_data;
  logic signed [SW-1:0] new_i, new_q;

  sample_fifo #(.WIDTH(2 * SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in({sample_i_in, sample_q_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(drain_ready),
    .out_data_out(fifo_data)
  );

  assign drain_ready = !out_valid_reg || out_ready_in;
  assign pop = fifo_valid && drain_ready;
  assign new_i = fifo_data[2*SW-1:SW];
  assign new_q = fifo_data[SW-1:0];

  // ****************************************
  // filter datapath
  // ****************************************
  logic signed [SW-1:0] hist_i_reg [WIN], hist_i_next [WIN];
  logic signed [SW-1:0] hist_q_reg [WIN], hist_q_next [WIN];
  logic signed [SW-1:0] casc_i_reg [WIN], casc_i_next [WIN];
  logic signed [SW-1:0] casc_q_reg [WIN], casc_q_next [WIN];
  logic signed [SW-1:0] win_i [WIN], win_q [WIN], cwin_i [WIN], cwin_q [WIN];
  logic signed [ACC-1:0] x_i, x_q, y_i, y_q, yd_i, yd_q, yc_i, yc_q;
  logic signed [SW-1:0] res_i, res_q;
  logic signed [SW-1:0] out_i_reg, out_i_next, out_q_reg, out_q_next;
  logic [2:0] first_gain, second_gain;

  assign first_gain = gain_reg[FIRST_GAIN_LSB+:GAIN_FIELD_W];
  assign second_gain = gain_reg[SECOND_GAIN_LSB+:GAIN_FIELD_W];

  always_comb begin
    win_i[0] = new_i;
    win_q[0] = new_q;
    for (int k = 1; k < WIN; k++) begin
      win_i[k] = hist_i_reg[k-1];
      win_q[k] = hist_q_reg[k-1];
    end
    // first bank: taps 0.. for i, taps TAPS.. for q
    x_i = gain(first_gain, fir(win_i, first_live_reg, 0, 0));
    x_q = gain(first_gain, fir(win_q, first_live_reg, 0, TAPS));
    y_i = gain(second_gain, fir(win_i, second_live_reg, 0, 0));
    y_q = gain(second_gain, fir(win_q, second_live_reg, 0, TAPS));
    yd_i = gain(second_gain, fir(win_i, second_live_reg, TAPS, 0));
    yd_q = gain(second_gain, fir(win_q, second_live_reg, TAPS, TAPS));
    cwin_i[0] = sat(x_i);
    cwin_q[0] = sat(x_q);
    for (int k = 1; k < WIN; k++) begin
      cwin_i[k] = casc_i_reg[k-1];
      cwin_q[k] = casc_q_reg[k-1];
    end
    yc_i = gain(second_gain, fir(cwin_i, second_live_reg, 0, 0));
    yc_q = gain(second_gain, fir(cwin_q, second_live_reg, 0, TAPS));
    unique case (filter_mode_in)
      MODE_SINGLE: begin
        res_i = sat(x_i);
        res_q = sat(x_q);
      end
      MODE_JOINED: begin
        res_i = sat(x_i + yd_i);
        res_q = sat(x_q + yd_q);
      end
      MODE_CASCADE: begin
        res_i = sat(yc_i);
        res_q = sat(yc_q);
      end
      MODE_COMPLEX: begin
        res_i = sat(x_i + y_q);
        res_q = sat(x_q + y_i);
      end
      default: begin
        // unlisted codes fall back to bypass
        res_i = new_i;
        res_q = new_q;
      end
    endcase
    hist_i_next = hist_i_reg;
    hist_q_next = hist_q_reg;
    casc_i_next = casc_i_reg;
    casc_q_next = casc_q_reg;
    out_i_next = out_i_reg;
    out_q_next = out_q_reg;
    out_valid_next = out_valid_reg && !out_ready_in;
    if (pop) begin
      hist_i_next = win_i;
      hist_q_next = win_q;
      casc_i_next = cwin_i;
      casc_q_next = cwin_q;
      out_i_next = res_i;
      out_q_next = res_q;
      out_valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      hist_i_reg <= '{default: '0};
      hist_q_reg <= '{default: '0};
      casc_i_reg <= '{default: '0};
      casc_q_reg <= '{default: '0};
      out_i_reg <= '0;
      out_q_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      hist_i_reg <= hist_i_next;
      hist_q_reg <= hist_q_next;
      casc_i_reg <= casc_i_next;
      casc_q_reg <= casc_q_next;
      out_i_reg <= out_i_next;
      out_q_reg <= out_q_next;
      out_valid_reg <= out_valid_next;
    end
  end

  assign out_valid_out = out_valid_reg;
  assign out_i_out = out_i_reg;
  assign out_q_out = out_q_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_bypass_pass: assert property (pop && filter_mode_in == MODE_BYPASS |=>
    out_valid_out && out_i_out == $past(new_i) && out_q_out == $past(new_q))
    else $error("bypass did not pass the sample through");
  a_single_first: assert property (pop && filter_mode_in == MODE_SINGLE |=>
    out_i_out == sat($past(x_i)) && out_q_out == sat($past(x_q)))
    else $error("single mode output is not the first bank result");
  a_joined_sum: assert property (pop && filter_mode_in == MODE_JOINED |=>
    out_i_out == sat($past(x_i) + $past(yd_i)) && out_q_out == sat($past(x_q) + $past(yd_q)))
    else $error("joined mode output is not the combined response");
  a_joined_delay: assert property (pop ##1 pop |-> hist_i_reg[TAPS] == $past(hist_i_reg[TAPS-1]))
    else $error("history line did not shift into the second bank window");
  a_cascade_chain: assert property (pop |=> casc_i_reg[0] == sat($past(x_i)))
    else $error("cascade line does not hold the first bank result");
  a_complex_cross: assert property (pop && filter_mode_in == MODE_COMPLEX |=>
    out_i_out == sat($past(x_i) + $past(y_q)) && out_q_out == sat($past(x_q) + $past(y_i)))
    else $error("complex mode did not cross the paths");
  a_gain_store: assert property (reg_wr_in && reg_addr_in == GAIN_ADDR |=>
    gain_reg[6:4] == $past(reg_wdata_in[6:4]) && gain_reg[2:0] == $past(reg_wdata_in[2:0]))
    else $error("gain fields not stored");
  a_gain_reserved: assert property (gain_reg[7] == 1'b0 && gain_reg[3] == 1'b0)
    else $error("reserved gain bits are not zero");
  a_coef_store: assert property (reg_wr_in && hit_first |=>
    first_shadow_reg[$past(idx)] == $past(reg_wdata_in))
    else $error("first bank coefficient not stored");
  a_live_hold: assert property (!transfer |=> first_live_reg[0] == $past(first_live_reg[0]) &&
    second_live_reg[0] == $past(second_live_reg[0]))
    else $error("live coefficients changed without a transfer");
  a_live_load: assert property (transfer |=> first_live_reg[0] == first_shadow_reg[0] &&
    second_live_reg[0] == second_shadow_reg[0])
    else $error("transfer did not load the live coefficients");
  a_live_copy: assert property (transfer ##1 !transfer |->
    first_live_reg[1] == first_shadow_reg[1] && second_live_reg[1] == second_shadow_reg[1])
    else $error("transfer did not copy the shadow coefficients");

endmodule : prog_fir_stage

/* test/prog_fir_sink.sv */
// Purpose: stand-in for the output framer that takes samples from the stage
// Assumes: one clock; ready changes just after the rising edge
// Notes: hold_in forces a long stall so that the fifo can be filled

`timescale 1ns/10ps

module prog_fir_sink (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // stall control and handshake
  input wire logic hold_in,
  output logic ready_out
);
  logic [31:0] lfsr_reg;

  // a pseudo-random pattern gives prompt and slow takes, about one stall in four
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      lfsr_reg <= 32'h1F2E3D4C;
      ready_out <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
      ready_out <= !hold_in && (lfsr_reg[1:0] != 2'h0);
    end
  end
endmodule : prog_fir_sink

/* test/prog_fir_stage_tb.sv */
// Purpose: self-checking bench for the programmable fir stage
// Assumes: configuration changes only while the stream is drained
// Notes: expected samples come from a behavioural model updated at each take

`timescale 1ns/10ps

module prog_fir_stage_tb import prog_fir_pkg::*;;
  localparam int SW = 16;
  localparam int TP = TAPS_DEF;
  logic clk_sys_in, nrst_in, reg_wr_in, reg_rd_in, reg_rvalid_out, sample_valid_in, sample_ready_out;
  logic out_valid_out, out_ready_in, hold;
  logic [15:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, gain;
  logic [2:0] filter_mode_in;
  logic signed [SW-1:0] sample_i_in, sample_q_in, out_i_out, out_q_out;
  logic [31:0] seed = 32'h8C7CAEE5;
  int fails = 0;
  int tests_run = 0;
  logic [7:0] sh [2][COEF_DEPTH];
  logic [7:0] lv [2][COEF_DEPTH];
  longint hi [2*TP], hq [2*TP], ci [2*TP], cq [2*TP];
  logic [2*SW-1:0] expq [$];
  bit chkq [$];

  prog_fir_stage #(.SW(SW), .TAPS(TP), .FIFO_DEPTH(FIFO_DEPTH_DEF)) prog_fir_stage_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .filter_mode_in(filter_mode_in), .sample_valid_in(sample_valid_in),
    .sample_ready_out(sample_ready_out), .sample_i_in(sample_i_in), .sample_q_in(sample_q_in),
    .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_i_out(out_i_out), .out_q_out(out_q_out));
  prog_fir_sink prog_fir_sink_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .hold_in(hold),
    .ready_out(out_ready_in));

  // ****************************************
  // model
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic longint sat(input longint v);
    longint lim;
    lim = longint'(1) <<< (SW - 1);
    return (v >= lim) ? lim - 1 : ((v < -lim) ? -lim : v);
  endfunction : sat

  // one bank over one path's history; gain shifts follow the bank's field
  function automatic longint fir(input longint h[2*TP], input int b, input int p, input int off);
    longint acc;
    acc = 0;
    for (int k = 0; k < TP; k++) acc += h[off+k] * longint'($signed(lv[b][p*TP+k]));
    acc = acc >>> 7;
    case (gain[b*4 +: 3])
      GAIN_LOSS_12: acc = acc >>> 2;
      GAIN_LOSS_6: acc = acc >>> 1;
      GAIN_PLUS_6: acc = acc <<< 1;
      GAIN_PLUS_12: acc = acc <<< 2;
      default: ;
    endcase
    return acc;
  endfunction : fir

  function automatic void model(input longint i, input longint q, input bit chk);
    longint ei, eq;
    for (int k = 2*TP-1; k > 0; k--) begin
      hi[k] = hi[k-1];
      hq[k] = hq[k-1];
      ci[k] = ci[k-1];
      cq[k] = cq[k-1];
    end
    hi[0] = i;
    hq[0] = q;
    ci[0] = sat(fir(hi, 0, 0, 0));
    cq[0] = sat(fir(hq, 0, 1, 0));
    ei = i;
    eq = q;
    case (filter_mode_in)
      MODE_SINGLE: begin
        ei = ci[0];
        eq = cq[0];
      end
      MODE_JOINED: begin
        ei = sat(fir(hi, 0, 0, 0) + fir(hi, 1, 0, TP));
        eq = sat(fir(hq, 0, 1, 0) + fir(hq, 1, 1, TP));
      end
      MODE_CASCADE: begin
        ei = sat(fir(ci, 1, 0, 0));
        eq = sat(fir(cq, 1, 1, 0));
      end
      MODE_COMPLEX: begin
        ei = sat(fir(hi, 0, 0, 0) + fir(hq, 1, 1, 0));
        eq = sat(fir(hq, 0, 1, 0) + fir(hi, 1, 0, 0));
      end
      default: ;
    endcase
    expq.push_back({ei[SW-1:0], eq[SW-1:0]});
    chkq.push_back(chk);
  endfunction : model

  // ****************************************
  // checks and drivers
  // ****************************************
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_smp(input logic [2*SW-1:0] got, input logic [2*SW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t sample got %h expected %h", $time, got, exp);
    end
  endtask : chk_smp

  always @(negedge clk_sys_in) begin
    if (out_valid_out === 1'b1 && out_ready_in === 1'b1) begin
      if (expq.size() == 0) chk_smp({out_i_out, out_q_out}, 'x);
      else if (chkq.pop_front()) chk_smp({out_i_out, out_q_out}, expq.pop_front());
      else void'(expq.pop_front());
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    if (a >= FIRST_BANK_BASE && a < SECOND_BANK_BASE + 16'h0080 && !a[7]) sh[a[8]][a[6:0]] = d;
    if (a == TRANSFER_ADDR && d[TRANSFER_BIT]) lv = sh;
    if (a == GAIN_ADDR) gain = d & 8'h77;
    @(posedge clk_sys_in);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk_reg({7'h00, reg_rvalid_out}, 8'h01);
    chk_reg(reg_rdata_out, exp);
    @(posedge clk_sys_in);
  endtask : rd

  task automatic push(input logic [31:0] iq, input bit chk, input int lim, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    sample_valid_in <= 1'b1;
    sample_i_in <= iq[31:16];
    sample_q_in <= iq[15:0];
    while (!ok && n < lim) begin
      @(negedge clk_sys_in);
      ok = (sample_ready_out === 1'b1);
      @(posedge clk_sys_in);
      n++;
    end
    if (ok) model(longint'($signed(iq[31:16])), longint'($signed(iq[15:0])), chk);
  endtask : push

  task automatic idle();
    sample_valid_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : idle

  task automatic stream(input int n, input bit chk);
    bit ok;
    for (int k = 0; k < n; k++) begin
      if (rnd() % 4 == 0) idle();
      push(chk ? rnd() : 32'h0, chk, 200, ok);
    end
    idle();
    for (int w = 0; w < 500 && expq.size() != 0; w++) @(posedge clk_sys_in);
  endtask : stream

  // ****************************************
  // sequence
  // ****************************************
  task automatic conclude();
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (40000) @(posedge clk_sys_in);
    fails++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] a;
    logic [2:0] modes [6];
    logic [2:0] codes [5];
    int n;
    bit ok;
    modes = '{MODE_BYPASS, MODE_SINGLE, MODE_JOINED, MODE_CASCADE, MODE_COMPLEX, 3'h3};
    // software keeps to the defined gain codes only
    codes = '{GAIN_LOSS_12, GAIN_LOSS_6, GAIN_UNITY, GAIN_PLUS_6, GAIN_PLUS_12};
    nrst_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 8'h00;
    filter_mode_in = MODE_SINGLE;
    sample_valid_in = 1'b0;
    sample_i_in = '0;
    sample_q_in = '0;
    hold = 1'b0;
    gain = GAIN_RESET;
    foreach (lv[b, k]) lv[b][k] = COEF_RESET;
    sh = lv;
    foreach (hi[k]) {hi[k], hq[k], ci[k], cq[k]} = '0;
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(GAIN_ADDR, GAIN_RESET);
    rd(FIRST_BANK_BASE + 16'h007F, COEF_RESET);
    rd(SECOND_BANK_BASE, COEF_RESET);
    wr(GAIN_ADDR, 8'hFF);
    rd(GAIN_ADDR, 8'h77);
    wr(16'h0E80, 8'h5A);
    rd(16'h0E80, 8'h00);
    rd(TRANSFER_ADDR, 8'h00);
    wr(GAIN_ADDR, 8'h00);
    wr(SECOND_BANK_BASE + 16'h007F, 8'hA5);
    rd(SECOND_BANK_BASE + 16'h007F, 8'hA5);
    for (int k = 0; k < 4*TP; k++) begin
      r = rnd();
      a = (k < 2*TP) ? FIRST_BANK_BASE + 16'(k) : SECOND_BANK_BASE + 16'(k - 2*TP);
      wr(a, r[7:0]);
      rd(a, r[7:0]);
    end
    // without the transfer the live banks still hold zero, so the output must be zero
    stream(12, 1'b1);
    wr(TRANSFER_ADDR, 8'h01);
    foreach (modes[m]) begin
      filter_mode_in <= modes[m];
      @(posedge clk_sys_in);
      if (modes[m] == MODE_CASCADE) stream(2*TP, 1'b0);
      foreach (codes[g]) begin
        wr(GAIN_ADDR, {1'b0, codes[g], 1'b0, (modes[m] == MODE_CASCADE) ? GAIN_UNITY : codes[g]});
        stream(10, 1'b1);
      end
    end
    // fill until refused with the far side stalled, then drain
    filter_mode_in <= MODE_BYPASS;
    hold <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    n = 0;
    ok = 1'b1;
    while (ok && n < 20) begin
      push(rnd(), 1'b1, 3, ok);
      if (ok) n++;
    end
    chk_reg(8'(n), 8'(FIFO_DEPTH_DEF + 1));
    hold <= 1'b0;
    stream(0, 1'b1);
    chk_reg(8'(expq.size()), 8'h00);
    conclude();
  end
endmodule : prog_fir_stage_tb
